//--- hdl/pwm_timer_pkg.sv
// Constants shared by the sixteen-bit PWM timer: register indices, fields, codes
package pwm_timer_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] REG_CTRLA = 6'h00;
  localparam logic [5:0] REG_CTRLB = 6'h01;
  localparam logic [5:0] REG_CTRLD = 6'h03;
  localparam logic [5:0] REG_CTRLECLR = 6'h04;
  localparam logic [5:0] REG_CONTROL_E_SET_REG = 6'h05;
  localparam logic [5:0] REG_CTRLFCLR = 6'h06;
  localparam logic [5:0] REG_CTRLFSET = 6'h07;
  localparam logic [5:0] REG_EVCTRL = 6'h09;
  localparam logic [5:0] REG_INTEN = 6'h0A;
  localparam logic [5:0] REG_INTERRUPT_FLAG_REG = 6'h0B;
  localparam logic [5:0] REG_CNT = 6'h20;
  localparam logic [5:0] REG_PER = 6'h26;
  localparam logic [5:0] REG_CMP0 = 6'h28;
  localparam logic [5:0] REG_CMP1 = 6'h2A;
  localparam logic [5:0] REG_CMP2 = 6'h2C;
  localparam logic [5:0] REG_PERBUF = 6'h36;
  localparam logic [5:0] REG_CMP0BUF = 6'h38;
  localparam logic [5:0] REG_CMP1BUF = 6'h3A;
  localparam logic [5:0] REG_CMP2BUF = 6'h3C;
  // Field positions
  localparam int CTRLA_EN = 0;
  localparam int CTRLA_CLK_LSB = 1;
  localparam int CTRLB_EN_LSB = 4;
  localparam int CTRLE_DIR = 0;
  localparam int CTRLE_LOCK_UPDATE = 1;
  localparam int CTRLE_CMD_LSB = 2;
  localparam int EV_COUNT_ON_EVENT_ENABLE = 0;
  localparam int EV_ACT_LSB = 1;
  localparam int FLG_OVF = 0;
  localparam int FLG_HIGH_UNDERFLOW_IRQ = 1;
  localparam int FLG_CMP_LSB = 4;
  // Waveform mode codes
  localparam logic [2:0] WG_SINGLE = 3'h3;
  localparam logic [2:0] WG_DS_TOP = 3'h5;
  localparam logic [2:0] WG_DS_BOTH = 3'h6;
  localparam logic [2:0] WG_DS_BOT = 3'h7;
  // Commands
  localparam logic [1:0] CMD_UPDATE = 2'h1;
  localparam logic [1:0] CMD_RESTART = 2'h2;
  localparam logic [1:0] CMD_RESET = 2'h3;
  // Event actions
  localparam logic [1:0] EV_POS = 2'h0;
  localparam logic [1:0] EV_ANY = 2'h1;
  localparam logic [1:0] EV_HIGH = 2'h2;
  localparam logic [1:0] EV_UPDOWN = 2'h3;
  // Interrupt vector offsets
  localparam logic [3:0] VEC_OVF = 4'h0;
  localparam logic [3:0] VEC_HIGH_UNDERFLOW_IRQ = 4'h2;
  localparam logic [3:0] VEC_CMP0 = 4'h4;
  localparam logic [3:0] VEC_STEP = 4'h2;
  // Prescaler: divide by 1,2,4,8,16,64,256,1024
  localparam int PRESC_W = 10;
  function automatic logic [9:0] presc_max(input logic [2:0] sel);
    logic [3:0] sh;
    sh = (sel < 3'h5) ? {1'b0, sel} : {sel, 1'b0} - 4'h4;
    return 10'((11'h001 << sh) - 11'h001);
  endfunction
endpackage

//--- hdl/sixteen_bit_timer_unit.sv
// Sixteen-bit PWM timer with split mode, events, flags and AHB-Lite registers
//
// Local design decisions: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
module sixteen_bit_timer_unit #(
  parameter int CW = 16,
  parameter int NCH = 3
) (
  // Clock, reset, clock enable
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Event input and port pins
  input wire logic event_in,
  input wire logic [2*NCH-1:0] port_out,
  input wire logic [2*NCH-1:0] pin_invert_enable,
  output logic [2*NCH-1:0] waveform_pin_output,
  output logic [2*NCH-1:0] pin_override,
  // Interrupt request and vector
  output logic irq_req,
  output logic [3:0] irq_vector
);
  // Register state
  logic [3:0] ctrla_q;
  logic [6:0] ctrlb_q;
  logic split_mode_enable;
  logic dir_q;
  logic lock_update;
  logic [NCH:0] bv_q;
  logic [2:0] evctrl_q;
  logic [6:0] interrupt_enable_reg;
  logic [6:0] interrupt_flag_reg;
  logic [CW-1:0] count_value;
  logic [CW-1:0] period_value;
  logic [CW-1:0] perbuf_q;
  logic [CW-1:0] compare_value_n [NCH];
  logic [CW-1:0] cmpbuf_q [NCH];
  logic [2*NCH-1:0] waveform_output;
  logic [NCH-1:0] hit_q;
  logic [pwm_timer_pkg::PRESC_W-1:0] presc_q;
  logic ev_s1_q, ev_s2_q, ev_s3_q;
  logic act_q, wr_q;
  logic [5:0] idx_q;
  logic [31:0] rdata_q;
  logic [2*NCH-1:0] pin_q;

  // Bus handshake: waits while the clock enable is low
  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  wire addr_take = ce && hready && hsel && htrans[1];
  wire [5:0] a_idx = haddr[7:2];
  wire a_map = (haddr[31:8] == 24'h00_0000);
  wire wr_fire = ce && act_q && wr_q;

  // Write strobes in the data phase
  wire we_ctrla = wr_fire && (idx_q == pwm_timer_pkg::REG_CTRLA);
  wire we_ctrlb = wr_fire && (idx_q == pwm_timer_pkg::REG_CTRLB);
  wire we_ctrld = wr_fire && (idx_q == pwm_timer_pkg::REG_CTRLD);
  wire we_eclr = wr_fire && (idx_q == pwm_timer_pkg::REG_CTRLECLR);
  wire we_eset = wr_fire && (idx_q == pwm_timer_pkg::REG_CONTROL_E_SET_REG);
  wire we_fclr = wr_fire && (idx_q == pwm_timer_pkg::REG_CTRLFCLR);
  wire we_fset = wr_fire && (idx_q == pwm_timer_pkg::REG_CTRLFSET);
  wire we_ev = wr_fire && (idx_q == pwm_timer_pkg::REG_EVCTRL);
  wire we_ien = wr_fire && (idx_q == pwm_timer_pkg::REG_INTEN);
  wire we_flg = wr_fire && (idx_q == pwm_timer_pkg::REG_INTERRUPT_FLAG_REG);
  wire we_cnt = wr_fire && (idx_q == pwm_timer_pkg::REG_CNT);
  wire we_per = wr_fire && (idx_q == pwm_timer_pkg::REG_PER);
  wire we_pbuf = wr_fire && (idx_q == pwm_timer_pkg::REG_PERBUF);

  // Commands from the set register
  wire [1:0] cmd = hwdata[pwm_timer_pkg::CTRLE_CMD_LSB +: 2];
  wire enable = ctrla_q[pwm_timer_pkg::CTRLA_EN];
  wire cmd_update = we_eset && (cmd == pwm_timer_pkg::CMD_UPDATE);
  wire cmd_restart = we_eset && (cmd == pwm_timer_pkg::CMD_RESTART);
  wire soft_rst = we_eset && (cmd == pwm_timer_pkg::CMD_RESET) && !enable;

  // Mode decode
  wire [2:0] waveform_mode_select = ctrlb_q[2:0];
  wire wg_single = (waveform_mode_select == pwm_timer_pkg::WG_SINGLE);
  wire wg_dual = (waveform_mode_select == pwm_timer_pkg::WG_DS_TOP) || (waveform_mode_select == pwm_timer_pkg::WG_DS_BOTH)
    || (waveform_mode_select == pwm_timer_pkg::WG_DS_BOT);
  wire split = split_mode_enable;
  wire [1:0] event_action_select = evctrl_q[pwm_timer_pkg::EV_ACT_LSB +: 2];
  wire count_ev = evctrl_q[pwm_timer_pkg::EV_COUNT_ON_EVENT_ENABLE] && !split;

  // Prescaler tick
  wire [pwm_timer_pkg::PRESC_W-1:0] pmax =
    pwm_timer_pkg::presc_max(ctrla_q[pwm_timer_pkg::CTRLA_CLK_LSB +: 3]);
  // Reaching or passing the limit ticks, so a smaller divider chosen mid-count cannot stall
  wire presc_tick = enable && (presc_q >= pmax);

  // Event edges from the synchronised input
  wire ev_rise = ev_s2_q && !ev_s3_q;
  wire ev_fall = !ev_s2_q && ev_s3_q;
  wire ev_tick = (event_action_select == pwm_timer_pkg::EV_POS) ? ev_rise :
    (event_action_select == pwm_timer_pkg::EV_ANY) ? (ev_rise || ev_fall) :
    (event_action_select == pwm_timer_pkg::EV_HIGH) ? (presc_tick && ev_s2_q) : presc_tick;
  wire tick = ce && enable && (count_ev ? ev_tick : presc_tick);
  wire dir_eff = (count_ev && event_action_select == pwm_timer_pkg::EV_UPDOWN) ? ev_s2_q : dir_q;

  // Normal-mode counting sequence
  wire at_top = (count_value >= period_value);
  wire at_bot = (count_value == '0);
  wire n_wrap = !wg_dual && !dir_eff && at_top;
  wire n_reload = !wg_dual && dir_eff && at_bot;
  wire n_turn_dn = wg_dual && !dir_eff && at_top;
  wire n_turn_up = wg_dual && dir_eff && at_bot;
  wire [CW-1:0] cnt_inc = count_value + CW'(1);
  wire [CW-1:0] cnt_dec = count_value - CW'(1);
  wire [CW-1:0] cnt_nx = n_wrap ? '0 : n_reload ? period_value :
    n_turn_up ? cnt_inc : n_turn_dn ? cnt_dec : dir_eff ? cnt_dec : cnt_inc;
  wire dir_nx = n_turn_dn ? 1'b1 : n_turn_up ? 1'b0 : dir_q;
  wire n_cycle = tick && !split && (n_wrap || n_reload || n_turn_up);

  // Update condition: natural one unless locked, or the command
  wire upd_top = (waveform_mode_select == pwm_timer_pkg::WG_DS_TOP) || (waveform_mode_select == pwm_timer_pkg::WG_DS_BOTH);
  wire nat_upd = n_cycle || (tick && !split && upd_top && n_turn_dn);
  wire do_upd = !split && ((nat_upd && !lock_update) || cmd_update);

  // Split-mode byte counters
  localparam int BW = CW / 2;
  wire [BW-1:0] low_byte_count = count_value[BW-1:0];
  wire [BW-1:0] high_byte_count = count_value[CW-1:BW];
  wire s_tick = ce && enable && presc_tick && split;
  wire l_unf = s_tick && (low_byte_count == '0);
  wire h_unf = s_tick && (high_byte_count == '0);
  wire [BW-1:0] l_nx = (low_byte_count == '0) ? period_value[BW-1:0] : low_byte_count - BW'(1);
  wire [BW-1:0] h_nx = (high_byte_count == '0) ? period_value[CW-1:BW] : high_byte_count - BW'(1);

  // Per-channel compare matches and next waveform values
  logic [NCH-1:0] n_match;
  logic [NCH-1:0] l_match;
  logic [NCH-1:0] h_match;
  logic [2*NCH-1:0] wg_nx;
  logic [NCH-1:0] buf_we;
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      n_match[i] = (cnt_nx == compare_value_n[i]);
      l_match[i] = (l_nx == compare_value_n[i][BW-1:0]);
      h_match[i] = (h_nx == compare_value_n[i][CW-1:BW]);
      buf_we[i] = wr_fire && (idx_q == pwm_timer_pkg::REG_CMP0BUF + 6'(2 * i));
      if (split)
      begin
        wg_nx[i] = l_match[i] ? 1'b1 : (low_byte_count == '0) ? 1'b0 : waveform_output[i];
        wg_nx[i+NCH] = h_match[i] ? 1'b1 : (high_byte_count == '0) ? 1'b0 : waveform_output[i+NCH];
      end
      else if (wg_dual)
      begin
        wg_nx[i] = n_match[i] ? dir_nx : (cnt_nx == '0) ? 1'b1 : waveform_output[i];
        wg_nx[i+NCH] = 1'b0;
      end
      else
      begin
        wg_nx[i] = n_match[i] ? 1'b0 : n_wrap ? 1'b1 : waveform_output[i];
        wg_nx[i+NCH] = 1'b0;
      end
    end
  end

  // Flags set by hardware; set wins over a software clear
  wire [NCH-1:0] l_hit = {NCH{s_tick}} & l_match;
  wire [NCH-1:0] n_hit = {NCH{tick && !split}} & n_match;
  wire [6:0] flag_set = {hit_q, 2'b00, split ? h_unf : 1'b0, split ? l_unf : n_cycle};
  wire [6:0] flag_clr = we_flg ? hwdata[6:0] : 7'h00;
  wire [6:0] flag_nx = (interrupt_flag_reg & ~flag_clr) | flag_set;
  wire [6:0] pend = interrupt_flag_reg & interrupt_enable_reg;

  // Pin override decode
  wire wave_on = split || wg_single || wg_dual;
  wire [2*NCH-1:0] ch_en = split ? {ctrlb_q[NCH-1:0], ctrlb_q[pwm_timer_pkg::CTRLB_EN_LSB +: NCH]}
    : {{NCH{1'b0}}, ctrlb_q[pwm_timer_pkg::CTRLB_EN_LSB +: NCH]};
  wire [2*NCH-1:0] ovr = ch_en & {2*NCH{wave_on}};
  wire [2*NCH-1:0] pin_nx = (ovr & (waveform_output ^ pin_invert_enable)) | (~ovr & port_out);
  assign waveform_pin_output = pin_q;
  assign pin_override = ovr;

  // Interrupt request and vector of the lowest pending source
  assign irq_req = |pend;
  assign irq_vector = pend[pwm_timer_pkg::FLG_OVF] ? pwm_timer_pkg::VEC_OVF :
    pend[pwm_timer_pkg::FLG_HIGH_UNDERFLOW_IRQ] ? pwm_timer_pkg::VEC_HIGH_UNDERFLOW_IRQ :
    pend[pwm_timer_pkg::FLG_CMP_LSB] ? pwm_timer_pkg::VEC_CMP0 :
    pend[pwm_timer_pkg::FLG_CMP_LSB+1] ? pwm_timer_pkg::VEC_CMP0 + pwm_timer_pkg::VEC_STEP :
    pend[pwm_timer_pkg::FLG_CMP_LSB+2] ? pwm_timer_pkg::VEC_CMP0 + 4'(2 * pwm_timer_pkg::VEC_STEP)
    : pwm_timer_pkg::VEC_OVF;

  // Read selection; wide registers hold low byte in 7:0 and high byte in 15:8
  wire [31:0] rd_cmp = (a_idx == pwm_timer_pkg::REG_CMP0) ? {16'h0000, compare_value_n[0]} :
    (a_idx == pwm_timer_pkg::REG_CMP1) ? {16'h0000, compare_value_n[1]} :
    (a_idx == pwm_timer_pkg::REG_CMP2) ? {16'h0000, compare_value_n[2]} :
    (a_idx == pwm_timer_pkg::REG_CMP0BUF) ? {16'h0000, cmpbuf_q[0]} :
    (a_idx == pwm_timer_pkg::REG_CMP1BUF) ? {16'h0000, cmpbuf_q[1]} :
    (a_idx == pwm_timer_pkg::REG_CMP2BUF) ? {16'h0000, cmpbuf_q[2]} : 32'h0000_0000;
  wire [31:0] rd_word = !a_map ? 32'h0000_0000 :
    (a_idx == pwm_timer_pkg::REG_CTRLA) ? {28'h000_0000, ctrla_q} :
    (a_idx == pwm_timer_pkg::REG_CTRLB) ? {25'h000_0000, ctrlb_q} :
    (a_idx == pwm_timer_pkg::REG_CTRLD) ? {31'h0000_0000, split_mode_enable} :
    (a_idx == pwm_timer_pkg::REG_CTRLECLR || a_idx == pwm_timer_pkg::REG_CONTROL_E_SET_REG)
      ? {30'h0000_0000, lock_update, dir_q} :
    (a_idx == pwm_timer_pkg::REG_CTRLFCLR || a_idx == pwm_timer_pkg::REG_CTRLFSET)
      ? {28'h000_0000, bv_q} :
    (a_idx == pwm_timer_pkg::REG_EVCTRL) ? {29'h0000_0000, evctrl_q} :
    (a_idx == pwm_timer_pkg::REG_INTEN) ? {25'h000_0000, interrupt_enable_reg} :
    (a_idx == pwm_timer_pkg::REG_INTERRUPT_FLAG_REG) ? {25'h000_0000, interrupt_flag_reg} :
    (a_idx == pwm_timer_pkg::REG_CNT) ? {16'h0000, count_value} :
    (a_idx == pwm_timer_pkg::REG_PER) ? {16'h0000, period_value} :
    (a_idx == pwm_timer_pkg::REG_PERBUF) ? {16'h0000, perbuf_q} : rd_cmp;

  // Bus address phase capture and read data
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      act_q <= 1'b0;
      wr_q <= 1'b0;
      idx_q <= 6'h00;
      rdata_q <= 32'h0000_0000;
    end
    else if (ce)
    begin
      act_q <= addr_take && a_map;
      wr_q <= hwrite;
      idx_q <= a_idx;
      rdata_q <= (addr_take && !hwrite) ? rd_word : 32'h0000_0000;
    end
  end

  // Event synchroniser and pin output register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      {ev_s1_q, ev_s2_q, ev_s3_q} <= 3'b000;
      pin_q <= '0;
    end
    else if (ce)
    begin
      {ev_s1_q, ev_s2_q, ev_s3_q} <= {event_in, ev_s1_q, ev_s2_q};
      pin_q <= pin_nx;
    end
  end

  // Control registers; reset command returns them to reset values
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrla_q <= 4'h0;
      ctrlb_q <= 7'h00;
      split_mode_enable <= 1'b0;
      lock_update <= 1'b0;
      evctrl_q <= 3'h0;
      interrupt_enable_reg <= 7'h00;
      interrupt_flag_reg <= 7'h00;
      presc_q <= '0;
      hit_q <= '0;
    end
    else if (ce && soft_rst)
    begin
      ctrla_q <= 4'h0;
      ctrlb_q <= 7'h00;
      split_mode_enable <= 1'b0;
      lock_update <= 1'b0;
      evctrl_q <= 3'h0;
      interrupt_enable_reg <= 7'h00;
      interrupt_flag_reg <= 7'h00;
      presc_q <= '0;
      hit_q <= '0;
    end
    else if (ce)
    begin
      if (we_ctrla) ctrla_q <= hwdata[3:0];
      if (we_ctrlb) ctrlb_q <= hwdata[6:0];
      if (we_ctrld) split_mode_enable <= hwdata[0];
      if (we_eset && hwdata[pwm_timer_pkg::CTRLE_LOCK_UPDATE]) lock_update <= 1'b1;
      else if (we_eclr && hwdata[pwm_timer_pkg::CTRLE_LOCK_UPDATE]) lock_update <= 1'b0;
      if (we_ev) evctrl_q <= hwdata[2:0];
      if (we_ien) interrupt_enable_reg <= hwdata[6:0];
      interrupt_flag_reg <= flag_nx;
      presc_q <= (!enable || presc_tick) ? '0 : presc_q + 1'b1;
      hit_q <= split ? l_hit : n_hit;
    end
  end

  // Counter, direction and waveforms; software counter write has priority
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      count_value <= '0;
      dir_q <= 1'b0;
      waveform_output <= '0;
    end
    else if (ce && (soft_rst || cmd_restart))
    begin
      count_value <= '0;
      dir_q <= 1'b0;
      waveform_output <= '0;
    end
    else if (ce)
    begin
      if (we_cnt) count_value <= hwdata[CW-1:0];
      else if (s_tick) count_value <= {h_nx, l_nx};
      else if (tick && !split) count_value <= cnt_nx;
      if (we_eset && hwdata[pwm_timer_pkg::CTRLE_DIR]) dir_q <= 1'b1;
      else if (we_eclr && hwdata[pwm_timer_pkg::CTRLE_DIR]) dir_q <= 1'b0;
      else if (tick && !split) dir_q <= dir_nx;
      if (s_tick || (tick && !split)) waveform_output <= wg_nx;
    end
  end

  // Period, compares and their buffers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      period_value <= '1;
      perbuf_q <= '1;
      bv_q <= '0;
      for (int i = 0; i < NCH; i++)
      begin
        compare_value_n[i] <= '0;
        cmpbuf_q[i] <= '0;
      end
    end
    else if (ce && soft_rst)
    begin
      period_value <= '1;
      perbuf_q <= '1;
      bv_q <= '0;
      for (int i = 0; i < NCH; i++)
      begin
        compare_value_n[i] <= '0;
        cmpbuf_q[i] <= '0;
      end
    end
    else if (ce)
    begin
      if (we_per) period_value <= hwdata[CW-1:0];
      else if (do_upd && bv_q[0]) period_value <= perbuf_q;
      if (we_pbuf) perbuf_q <= hwdata[CW-1:0];
      for (int i = 0; i < NCH; i++)
      begin
        if (wr_fire && idx_q == pwm_timer_pkg::REG_CMP0 + 6'(2 * i))
          compare_value_n[i] <= hwdata[CW-1:0];
        else if (do_upd && bv_q[i+1]) compare_value_n[i] <= cmpbuf_q[i];
        if (buf_we[i]) cmpbuf_q[i] <= hwdata[CW-1:0];
      end
      // Valid flags: buffer write sets, update clears; unused in split mode
      if (!split)
        bv_q <= ((bv_q & ~(do_upd ? '1 : '0) & ~(we_fclr ? hwdata[NCH:0] : '0))
          | (we_fset ? hwdata[NCH:0] : '0) | {buf_we, we_pbuf});
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence restart_seq;
    ce && cmd_restart && !soft_rst;
  endsequence
  sequence wrap_seq;
    tick && !split && !wg_dual && !dir_eff && at_top && !we_cnt && !cmd_restart;
  endsequence
  restart_clear_a: assert property (restart_seq |=> count_value == '0 && !dir_q
    && waveform_output == '0) else $error("restart left counter or waveform set");
  wrap_zero_a: assert property (wrap_seq |=> count_value == '0)
    else $error("single slope did not wrap to zero");
  ovf_flag_a: assert property (wrap_seq |=> interrupt_flag_reg[0])
    else $error("overflow flag not raised at wrap");
  cmp_flag_a: assert property (ce && n_hit[0] && !soft_rst ##1 ce |=>
    interrupt_flag_reg[pwm_timer_pkg::FLG_CMP_LSB]) else $error("compare flag late");
  irq_hold_a: assert property (pend[0] && !we_flg && !we_ien && !soft_rst |=> irq_req)
    else $error("interrupt request dropped without clear");
  reset_ignored_a: assert property (we_eset && cmd == pwm_timer_pkg::CMD_RESET && enable
    && !we_ctrla |=> ctrla_q[0]) else $error("reset acted while enabled");
  dual_turn_a: assert property (ce && tick && !split && n_turn_dn && !we_eclr && !cmd_restart
    && !we_cnt
    |=> dir_q && count_value == $past(cnt_dec)) else $error("dual slope did not turn at top");
  split_bv_a: assert property (ce && split && !soft_rst |=> $stable(bv_q))
    else $error("buffer valid changed in split mode");
  upd_cmd_a: assert property (ce && cmd_update && bv_q[0] && !split && !we_per
    |=> period_value == $past(perbuf_q)) else $error("update command ignored");
  pin_inv_a: assert property (ce && ovr[0] && pin_invert_enable[0]
    |=> pin_q[0] == !$past(waveform_output[0])) else $error("pin not inverted");
  div1_a: assert property (enable && ctrla_q[3:1] == 3'h0 |-> presc_tick)
    else $error("divide by one gave no tick");
endmodule

//--- verif/pin_load_model.sv
// Port pins model: external loads on the timer pins, counting high samples
`timescale 1ns/1ps
module pin_load_model (
  // Clock and count clear
  input wire logic clk,
  input wire logic clr,
  // Pins as seen by the loads
  input wire logic [5:0] pin,
  output logic [7:0] highs
);
  // Pins are outputs, so the load sees the driven level of pin 0
  always_ff @(posedge clk)
  begin
    if (clr)
      highs <= 8'h00;
    else
      highs <= highs + {7'h00, pin[0]};
  end
endmodule

//--- verif/testbench.sv
// Self-checking bench for the sixteen-bit PWM timer
`timescale 1ns/1ps
module testbench;
  logic clk, nrst, ce, hsel, hwrite, hreadyout, hresp, event_in, irq_req, clr;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [5:0] port_out, pin_invert_enable, waveform_pin_output, pin_override;
  logic [3:0] irq_vector;
  logic [7:0] highs;
  int n_errors, check_count;
  sixteen_bit_timer_unit i_sixteen_bit_timer_unit (.clk(clk), .nrst(nrst), .ce(ce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .event_in(event_in), .port_out(port_out),
    .pin_invert_enable(pin_invert_enable), .waveform_pin_output(waveform_pin_output),
    .pin_override(pin_override), .irq_req(irq_req), .irq_vector(irq_vector));
  pin_load_model i_pin_load_model (.clk(clk), .clr(clr), .pin(waveform_pin_output),
    .highs(highs));
  // Clock
  initial
  begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // One single AHB-Lite transfer; read data lands in q
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [5:0] i, input logic [31:0] d);
    xfer(1'b1, {24'h0000_00, i, 2'b00}, d);
  endtask
  task automatic rd(input logic [5:0] i);
    xfer(1'b0, {24'h0000_00, i, 2'b00}, 32'h0000_0000);
  endtask
  // Let the waveform settle, then count high pin samples over len cycles
  task automatic duty(input int len, input logic [7:0] exp, input string nm);
    repeat (40) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (len) @(posedge clk);
    @(negedge clk);
    chk(nm, {24'h0000_00, highs}, {24'h0000_00, exp});
    @(posedge clk);
  endtask
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end
  int n;
  initial
  begin
    {nrst, ce, hsel, hwrite, event_in, clr, htrans, hsize} = {2'b01, 6'h00, 3'h2};
    {haddr, hwdata} = 64'h0;
    void'($urandom(70159));
    pin_invert_enable = 6'($urandom);
    port_out = 6'($urandom);
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(pwm_timer_pkg::REG_PER);
    chk("per_reset", q, 32'h0000_FFFF);
    xfer(1'b0, 32'h0000_1000, 32'h0000_0000);
    chk("unmapped", q, 32'h0000_0000);
    // Disabled channel leaves the port value on the pin
    wr(pwm_timer_pkg::REG_CTRLB, {29'h0, pwm_timer_pkg::WG_SINGLE});
    repeat (3) @(posedge clk);
    chk("no_ovr", {26'h0, pin_override}, 32'h0000_0000);
    chk("port_pass", {26'h0, waveform_pin_output}, {26'h0, port_out});
    // Single slope, period 3, compare 1: one high tick in four, per prescaler
    wr(pwm_timer_pkg::REG_PER, 32'h0000_0003);
    wr(pwm_timer_pkg::REG_CMP0, 32'h0000_0001);
    wr(pwm_timer_pkg::REG_CTRLB, {25'h0, 3'h1, 1'b0, pwm_timer_pkg::WG_SINGLE});
    for (int c = 0; c < 3; c++)
    begin
      n = 1 << c;
      wr(pwm_timer_pkg::REG_CTRLA, 32'(2 * c + 1));
      duty(8 * n, 8'(pin_invert_enable[0] ? 6 * n : 2 * n), "ss_duty");
    end
    chk("ovr_on", {31'h0, pin_override[0]}, 32'h0000_0001);
    // Dual slope, period 3, compare 1: two high ticks in six
    wr(pwm_timer_pkg::REG_CTRLA, 32'h0000_0001);
    wr(pwm_timer_pkg::REG_CTRLB, {25'h0, 3'h1, 1'b0, pwm_timer_pkg::WG_DS_BOTH});
    duty(12, pin_invert_enable[0] ? 8'h08 : 8'h04, "ds_duty");
    // Flags, masking and clearing
    wr(pwm_timer_pkg::REG_CTRLA, 32'h0000_0000);
    rd(pwm_timer_pkg::REG_INTERRUPT_FLAG_REG);
    chk("flags", q & 32'h0000_0011, 32'h0000_0011);
    chk("irq_masked", {31'h0, irq_req}, 32'h0000_0000);
    wr(pwm_timer_pkg::REG_INTEN, 32'h0000_0001);
    // The enable lands at this edge; look once it has settled
    @(negedge clk);
    chk("irq_on", {27'h0, irq_req, irq_vector}, 32'h0000_0010);
    @(posedge clk);
    wr(pwm_timer_pkg::REG_INTERRUPT_FLAG_REG, 32'h0000_0011);
    @(posedge clk);
    chk("irq_off", {31'h0, irq_req}, 32'h0000_0000);
    // Restart clears counter, direction and waveform
    wr(pwm_timer_pkg::REG_CONTROL_E_SET_REG, 32'h0000_0001);
    wr(pwm_timer_pkg::REG_CONTROL_E_SET_REG, {28'h0, pwm_timer_pkg::CMD_RESTART, 2'b00});
    rd(pwm_timer_pkg::REG_CNT);
    chk("cnt_restart", q, 32'h0000_0000);
    rd(pwm_timer_pkg::REG_CONTROL_E_SET_REG);
    chk("dir_restart", q & 32'h0000_0001, 32'h0000_0000);
    chk("wg_restart", {31'h0, waveform_pin_output[0]}, {31'h0, pin_invert_enable[0]});
    // Reset command ignored while enabled, obeyed while disabled
    wr(pwm_timer_pkg::REG_PER, 32'h0000_0005);
    wr(pwm_timer_pkg::REG_CTRLA, 32'h0000_0001);
    wr(pwm_timer_pkg::REG_CONTROL_E_SET_REG, {28'h0, pwm_timer_pkg::CMD_RESET, 2'b00});
    rd(pwm_timer_pkg::REG_PER);
    chk("reset_busy", q, 32'h0000_0005);
    wr(pwm_timer_pkg::REG_CTRLA, 32'h0000_0000);
    wr(pwm_timer_pkg::REG_CONTROL_E_SET_REG, {28'h0, pwm_timer_pkg::CMD_RESET, 2'b00});
    rd(pwm_timer_pkg::REG_PER);
    chk("reset_per", q, 32'h0000_FFFF);
    rd(pwm_timer_pkg::REG_CTRLB);
    chk("reset_ctrlb", q, 32'h0000_0000);
    // Update command with the lock set still moves the period buffer
    wr(pwm_timer_pkg::REG_PERBUF, 32'h0000_0007);
    wr(pwm_timer_pkg::REG_CONTROL_E_SET_REG, {28'h0, pwm_timer_pkg::CMD_UPDATE, 2'b10});
    rd(pwm_timer_pkg::REG_PER);
    chk("upd_locked", q, 32'h0000_0007);
    wr(pwm_timer_pkg::REG_CTRLA, 32'h0000_0000);
    wr(pwm_timer_pkg::REG_CONTROL_E_SET_REG, {28'h0, pwm_timer_pkg::CMD_RESET, 2'b00});
    // Split start order: split bit, periods, then enable; low compare 1 of 3
    wr(pwm_timer_pkg::REG_CTRLD, 32'h0000_0001);
    wr(pwm_timer_pkg::REG_PER, 32'h0000_0303);
    wr(pwm_timer_pkg::REG_CMP0, 32'h0000_0001);
    wr(pwm_timer_pkg::REG_CTRLB, 32'h0000_0010);
    wr(pwm_timer_pkg::REG_CTRLA, 32'h0000_0001);
    duty(8, 8'h04, "split_duty");
    wr(pwm_timer_pkg::REG_CTRLA, 32'h0000_0000);
    rd(pwm_timer_pkg::REG_INTERRUPT_FLAG_REG);
    chk("split_unf", q & 32'h0000_0003, 32'h0000_0003);
    tally_and_finish();
  end
endmodule
